// ===== hdl/sadc_ctrl.sv
// Purpose: apb register file and sequencing of a 10-bit sar converter
// Assumes: comparator result arrives on I_SAR_RESULT when conversion ends
// Notes:   standby input holds control registers at reset and locks them
//
// Decided for this implementation: the APB register port.
module sadc_ctrl
  import sadc_pkg::*;
(
  input  wire logic        I_MCLK,
  input  wire logic        I_SRST,
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [9:0]  I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  input  wire logic        I_STANDBY,       // stop/slow/sleep entry, from pin
  input  wire logic [9:0]  I_SAR_RESULT,    // analog result bits
  output logic [31:0]      O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  output logic [3:0]       O_CHANNEL_SELECT,
  output logic             O_ANALOG_INPUT_DISABLE,
  output logic             O_LADDER_CONNECT,
  output logic             O_SAMPLE,        // conversion in progress
  output logic             O_CONV_DONE_IRQ  // one-cycle request
);
  sadc_ctrl_one_s ctl1_ff;               // conv_control_one
  logic [7:0]     ctl2_ff;               // conv_control_two
  sadc_result_s   res_ff;                // stored result
  logic           done_ff;               // conv_done_flag
  logic           sb_meta_ff, sb_ff;     // standby synchroniser
  logic           start_go;              // start accepted this cycle
  logic           abort;                 // conversion killed
  logic           run, t_done;           // timer state
  logic           wr_acc, rd_acc;        // apb access phases
  logic [7:0]     idx;                   // register index
  logic           mapped;
  logic [7:0]     rd_byte;

  // standby pin crossing
  always_ff @(posedge I_MCLK) begin
    if (I_SRST) begin
      sb_meta_ff <= 1'b0;
      sb_ff      <= 1'b0;
    end else begin
      sb_meta_ff <= I_STANDBY;
      sb_ff      <= sb_meta_ff;
    end
  end

  assign idx    = I_PADDR[9:2];
  assign mapped = (idx >= SADC_IDX_CTRL_ONE) && (idx <= SADC_IDX_RES_HIGH);
  assign wr_acc = I_PSEL && I_PENABLE && I_PWRITE && O_PREADY;
  assign rd_acc = I_PSEL && I_PENABLE && !I_PWRITE && O_PREADY;

  // start taken in software or repeat mode when idle
  assign start_go = ctl1_ff.start && !run && !sb_ff &&
                    (ctl1_ff.mode == SADC_MODE_SW ||
                     ctl1_ff.mode == SADC_MODE_REPEAT); // see [R1] [R2]
  // repeat chains a new conversion on each completion
  logic chain;
  assign chain = t_done && ctl1_ff.mode == SADC_MODE_REPEAT && !sb_ff; // see [R19]
  // leaving an active mode or standby stops at once
  assign abort = run && (sb_ff || ctl1_ff.mode == SADC_MODE_OFF ||
                 ctl1_ff.mode == 2'h2); // see [R20] [R11]

  sadc_timer u_timer (
    .i_clk   (I_MCLK),
    .i_rst   (I_SRST),
    .i_start (start_go || chain),
    .i_abort (abort),
    .i_code  (ctl2_ff[SADC_TIME_POS +: 3]),
    .o_run   (run),
    .o_done  (t_done)
  );

  // control register one
  always_ff @(posedge I_MCLK) begin
    if (I_SRST || sb_ff) begin
      ctl1_ff <= sadc_ctrl_one_s'(SADC_CTRL_ONE_RST); // see [R13]
    end else if (wr_acc && idx == SADC_IDX_CTRL_ONE) begin
      ctl1_ff <= sadc_ctrl_one_s'(I_PWDATA[7:0]);
    end else if (start_go) begin
      ctl1_ff.start <= 1'b0; // see [R7]
    end
  end

  // control register two
  always_ff @(posedge I_MCLK) begin
    if (I_SRST || sb_ff) begin
      ctl2_ff <= SADC_CTRL_TWO_RST; // see [R13]
    end else if (wr_acc && idx == SADC_IDX_CTRL_TWO) begin
      ctl2_ff <= I_PWDATA[7:0];
    end
  end

  // result capture only on a completed conversion
  always_ff @(posedge I_MCLK) begin
    if (I_SRST || sb_ff) begin
      res_ff <= sadc_result_s'({2'h0, SADC_RES_HIGH_RST});
    end else if (t_done) begin
      res_ff.value <= I_SAR_RESULT; // see [R8]
    end
  end

  // done flag: set wins over read clear
  always_ff @(posedge I_MCLK) begin
    if (I_SRST || sb_ff) begin
      done_ff <= 1'b0;
    end else if (t_done) begin
      done_ff <= 1'b1; // see [R8]
    end else if (rd_acc && idx == SADC_IDX_RES_HIGH) begin
      done_ff <= 1'b0; // see [R10]
    end
  end

  // read mux; unstable/undefined bits read as zero
  always_comb begin
    unique case (idx)
      SADC_IDX_CTRL_ONE: rd_byte = ctl1_ff;
      SADC_IDX_CTRL_TWO: rd_byte = {2'h0, ctl2_ff[5:0]}; // see [R12]
      SADC_IDX_RES_LOW:  rd_byte = {res_ff.value[1:0], done_ff, run, 4'h0}; // see [R9] [R11]
      SADC_IDX_RES_HIGH: rd_byte = res_ff.value[9:2]; // see [R9]
      default:           rd_byte = 8'h00;
    endcase
  end

  // apb: one wait state, error on unmapped
  always_ff @(posedge I_MCLK) begin
    if (I_SRST) begin
      O_PREADY  <= 1'b0;
      O_PRDATA  <= 32'h0000_0000;
      O_PSLVERR <= 1'b0;
    end else begin
      O_PREADY  <= I_PSEL && I_PENABLE && !O_PREADY;
      O_PRDATA  <= {24'h00_0000, rd_byte};
      O_PSLVERR <= I_PSEL && I_PENABLE && !O_PREADY && !mapped;
    end
  end

  // analog side controls
  always_ff @(posedge I_MCLK) begin
    if (I_SRST) begin
      O_CHANNEL_SELECT       <= 4'h0;
      O_ANALOG_INPUT_DISABLE <= 1'b1;
      O_LADDER_CONNECT       <= 1'b0;
      O_SAMPLE               <= 1'b0;
      O_CONV_DONE_IRQ        <= 1'b0;
    end else begin
      O_CHANNEL_SELECT       <= ctl1_ff.chan; // see [R3]
      O_ANALOG_INPUT_DISABLE <= ctl1_ff.in_dis; // see [R4]
      O_LADDER_CONNECT       <= ctl2_ff[SADC_LADDER_POS] || run; // see [R5]
      O_SAMPLE               <= run;
      O_CONV_DONE_IRQ        <= t_done; // see [R8]
    end
  end

  chk_start_clears: assert property (@(posedge I_MCLK) disable iff (I_SRST)
    start_go |=> !ctl1_ff.start) // see [R7]
    else $error("start bit did not clear");
  chk_start_busy: assert property (@(posedge I_MCLK) disable iff (I_SRST)
    (start_go && !abort) |=> run) // see [R1]
    else $error("conversion did not begin");
  chk_done_flag: assert property (@(posedge I_MCLK) disable iff (I_SRST)
    (t_done && !sb_ff) |=> done_ff && res_ff.value == $past(I_SAR_RESULT)) // see [R8]
    else $error("completion not recorded");
  chk_irq_pulse: assert property (@(posedge I_MCLK) disable iff (I_SRST)
    t_done |=> O_CONV_DONE_IRQ) // see [R8]
    else $error("irq missing");
  chk_read_clear: assert property (@(posedge I_MCLK) disable iff (I_SRST)
    (rd_acc && idx == SADC_IDX_RES_HIGH && !t_done && !sb_ff) |=> !done_ff) // see [R10]
    else $error("done not cleared by read");
  chk_repeat_chain: assert property (@(posedge I_MCLK) disable iff (I_SRST)
    (chain && !abort) |=> run) // see [R19]
    else $error("repeat did not restart");
  chk_abort_nostore: assert property (@(posedge I_MCLK) disable iff (I_SRST)
    (abort && !sb_ff && !rd_acc) |=> $stable(res_ff) && done_ff == $past(done_ff)) // see [R20]
    else $error("abort stored result");
  chk_standby_reset: assert property (@(posedge I_MCLK) disable iff (I_SRST)
    sb_ff |=> ctl1_ff == SADC_CTRL_ONE_RST && !run) // see [R13]
    else $error("standby did not reset");
  chk_ladder: assert property (@(posedge I_MCLK) disable iff (I_SRST)
    run |=> O_LADDER_CONNECT) // see [R5]
    else $error("ladder off during conversion");
  cov_sw_done: cover property (@(posedge I_MCLK) disable iff (I_SRST)
    start_go ##[1:1000] t_done);
  cov_repeat: cover property (@(posedge I_MCLK) disable iff (I_SRST) chain);
  cov_abort: cover property (@(posedge I_MCLK) disable iff (I_SRST) abort);
endmodule

// ===== include/sadc_pkg.sv
// Purpose: constants and carriers for the sar converter control block
// Assumes: 32-bit apb, byte registers in the low bits of each word
// Notes:   register index is the printed offset, byte address is index*4
// Summary of operation
// [R1] software-start mode plus start bit begins conversion
// [R2] mode 00 off, 01 software, 11 repeat
// [R3] channel code n selects analog input n
// [R4] input disable bit: 0 enable, 1 disable
// [R5] ladder on during conversion, or always when set
// [R6] time code picks 39 to 1248 clock periods
// [R7] start bit self-clears once conversion begins
// [R8] completion stores result, sets done, raises irq
// [R9] result bits 9..2 high, 1..0 in low reg
// [R10] reading high result register clears done flag
// [R11] busy set on start, cleared on end/standby
// [R12] unstable low status bits and control-two top bits
// [R13] standby resets control registers and blocks writes
// [R14] software writes bit0 zero, bit4 one
// [R15] software never restarts during a running conversion
// [R16] software changes channel only while idle
// [R17] software reads low status before high result
// [R18] software disables inputs when none used
// [R19] repeat mode restarts after every completion
// [R20] disable in repeat stops, no result stored
// [R21] busy held for selected time, done withheld
package sadc_pkg;
  localparam logic [7:0] SADC_IDX_CTRL_ONE  = 8'h1c; // conv_control_one
  localparam logic [7:0] SADC_IDX_CTRL_TWO  = 8'h1d; // conv_control_two
  localparam logic [7:0] SADC_IDX_RES_LOW   = 8'h1e; // result_low_status
  localparam logic [7:0] SADC_IDX_RES_HIGH  = 8'h1f; // result_high
  localparam logic [7:0] SADC_CTRL_ONE_RST  = 8'h10; // input disable set
  localparam logic [7:0] SADC_CTRL_TWO_RST  = 8'h00; // time 000, ladder off
  localparam logic [7:0] SADC_RES_HIGH_RST  = 8'h00;
  localparam logic [1:0] SADC_MODE_OFF      = 2'h0;
  localparam logic [1:0] SADC_MODE_SW       = 2'h1;
  localparam logic [1:0] SADC_MODE_REPEAT   = 2'h3;
  localparam int         SADC_START_POS     = 7;
  localparam int         SADC_MODE_POS      = 5;
  localparam int         SADC_DIS_POS       = 4;
  localparam int         SADC_LADDER_POS    = 5;
  localparam int         SADC_TIME_POS      = 1;
  localparam int         SADC_DONE_POS      = 5;
  localparam int         SADC_BUSY_POS      = 4;
  localparam int         SADC_RES_W         = 10;
  localparam logic [11:0] SADC_T39   = 12'h027; // 39 clock periods
  localparam logic [11:0] SADC_T78   = 12'h04e;
  localparam logic [11:0] SADC_T156  = 12'h09c;
  localparam logic [11:0] SADC_T312  = 12'h138;
  localparam logic [11:0] SADC_T624  = 12'h270;
  localparam logic [11:0] SADC_T1248 = 12'h4e0;
  // control register one fields
  typedef struct packed {
    logic       start;
    logic [1:0] mode;
    logic       in_dis;
    logic [3:0] chan;
  } sadc_ctrl_one_s;
  // conversion result value only, no channel
  typedef struct packed {
    logic [9:0] value;
  } sadc_result_s;
endpackage

// ===== hdl/sadc_timer.sv
// Purpose: conversion-time counter for the sar converter control
// Assumes: one start pulse per conversion, abort clears it
// Notes:   done pulses once after the selected number of cycles
module sadc_timer
  import sadc_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_start,   // begin counting
  input  wire logic        i_abort,   // stop, no done
  input  wire logic [2:0]  i_code,    // conversion time code
  output logic             o_run,     // counting
  output logic             o_done     // one-cycle completion pulse
);
  logic [11:0] cnt_ff;                // cycles remaining
  logic [11:0] len;                   // decoded length

  // decode time code; reserved codes fall back to shortest
  always_comb begin
    unique case (i_code) // see [R6]
      3'h2:    len = SADC_T78;
      3'h3:    len = SADC_T156;
      3'h4:    len = SADC_T312;
      3'h5:    len = SADC_T624;
      3'h6:    len = SADC_T1248;
      default: len = SADC_T39;
    endcase
  end

  // countdown; done on the last cycle
  always_ff @(posedge i_clk) begin
    o_done <= 1'b0;
    if (i_rst || i_abort) begin
      cnt_ff <= 12'h000;
      o_run  <= 1'b0;
    end else if (i_start) begin
      cnt_ff <= len - 12'h001; // see [R21]
      o_run  <= 1'b1;
    end else if (o_run) begin
      if (cnt_ff == 12'h001) begin
        o_run  <= 1'b0;
        o_done <= 1'b1;
      end
      cnt_ff <= cnt_ff - 12'h001;
    end
  end

  chk_timer_len: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_start && !i_abort && i_code == 3'h0) |-> ##39 o_done) // see [R21]
    else $error("short conversion length wrong");
endmodule

// ===== verification/tb_sar_adc_control.sv
// Purpose: self-checking bench for the sar converter control block
// Assumes: apb slave answers within a few cycles, standby sync takes 2 cycles
// Notes:   channels and results are random from a fixed seed
module tb_sar_adc_control
  import sadc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk, srst, psel, pen, pwr, stby, pready, err, dis, lad_o, smp, irq;
  logic [9:0]  paddr, sar, r, pr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  chan, ch;
  logic        seen;             // irq seen while idle
  int          failures, n_tests, c0;
  int          cyc = 0;          // free cycle count
  int          tn[8] = '{39, 39, 78, 156, 312, 624, 1248, 39}; // reserved codes as 39
  sadc_ctrl uut (.I_MCLK(clk), .I_SRST(srst), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .I_STANDBY(stby),
    .I_SAR_RESULT(sar), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(err),
    .O_CHANNEL_SELECT(chan), .O_ANALOG_INPUT_DISABLE(dis),
    .O_LADDER_CONNECT(lad_o), .O_SAMPLE(smp), .O_CONV_DONE_IRQ(irq));
  // 250 MHz clock and cycle count
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  // verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // compare seen against expected
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      failures++;
      $display("BAD t=%0t seen %h want %h", $time, s, e);
    end
  endtask
  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge clk);
    pen <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    psel <= 1'b0;
    pen <= 1'b0;
    if (k >= 50) begin
      failures++;
      close_out();
    end
  endtask
  // wait for the completion pulse, bounded
  task automatic wait_irq();
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (irq !== 1'b1 && k < 1400);
    if (k >= 1400) begin
      failures++;
      close_out();
    end
  endtask
  // main sequence
  initial begin
    void'($urandom(32'h0c5d66a9));
    {srst, psel, pen, pwr, stby} = 5'h10;
    paddr = '0;
    pwdata = '0;
    sar = '0;
    pr = '0;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    // reset values, unstable bits read 0
    apb(0, SADC_IDX_CTRL_ONE, 8'h0); chk(rd, 32'(SADC_CTRL_ONE_RST));
    apb(0, SADC_IDX_CTRL_TWO, 8'h0); chk(rd, 32'(SADC_CTRL_TWO_RST));
    apb(0, SADC_IDX_RES_HIGH, 8'h0); chk(rd, 32'(SADC_RES_HIGH_RST));
    apb(0, SADC_IDX_RES_LOW, 8'h0); chk(rd, 32'h0);
    chk(32'(dis), 32'h1);
    // unmapped index refused
    apb(0, 8'h20, 8'h0); chk({rd[30:0], err}, 32'h1);
    // every channel code, disable bit toggled
    for (int i = 0; i < 16; i++) begin
      apb(1, SADC_IDX_CTRL_ONE, {1'b0, SADC_MODE_OFF, i[0], i[3:0]});
      repeat (2) @(posedge clk); // outputs follow the register one edge later
      chk(32'({chan, dis}), 32'({i[3:0], i[0]}));
    end
    // disabled and reserved modes ignore start
    for (int m = 0; m < 3; m += 2) begin
      apb(1, SADC_IDX_CTRL_ONE, {1'b1, m[1:0], 5'h0});
      repeat (5) @(posedge clk);
      chk(32'(smp), 32'h0);
    end
    // each conversion time code
    for (int i = 0; i < 8; i++) begin
      ch = 4'($urandom);
      r = 10'($urandom);
      sar <= r;
      apb(1, SADC_IDX_CTRL_TWO, {2'h0, i[0], 1'b1, i[2:0], 1'b0});
      // channel changes only here, while idle
      apb(1, SADC_IDX_CTRL_ONE, {1'b1, SADC_MODE_SW, 1'b0, ch});
      c0 = cyc;
      apb(0, SADC_IDX_CTRL_ONE, 8'h0); chk(rd, 32'({SADC_MODE_SW, 1'b0, ch}));
      chk(32'({smp, lad_o, chan}), 32'({2'b11, ch}));
      // earlier result stays until this conversion ends
      apb(0, SADC_IDX_RES_LOW, 8'h0); chk(rd, 32'({pr[1:0], 6'h10}));
      // next start only after the done pulse
      wait_irq(); chk(32'(cyc - c0 >= tn[i] && cyc - c0 <= tn[i] + 4), 32'h1);
      // low status read before high result
      apb(0, SADC_IDX_RES_LOW, 8'h0); chk(rd, 32'({r[1:0], 6'h20}));
      apb(0, SADC_IDX_RES_HIGH, 8'h0); chk(rd, 32'(r[9:2]));
      apb(0, SADC_IDX_RES_LOW, 8'h0); chk(32'(rd[5]), 32'h0);
      chk(32'(lad_o), 32'(i[0]));
      pr = r;
    end
    // repeat mode, then stop mid-conversion
    r = 10'($urandom);
    sar <= r;
    apb(1, SADC_IDX_CTRL_ONE, {1'b1, SADC_MODE_REPEAT, 1'b0, ch});
    wait_irq();
    c0 = cyc;
    wait_irq(); chk(32'(cyc - c0 >= 39 && cyc - c0 <= 43), 32'h1);
    sar <= ~r;
    apb(1, SADC_IDX_CTRL_ONE, {1'b0, SADC_MODE_OFF, 1'b0, ch});
    seen = 1'b0;
    repeat (60) begin
      @(posedge clk);
      seen |= irq;
    end
    chk(32'({seen, smp}), 32'h0);
    apb(0, SADC_IDX_RES_HIGH, 8'h0); chk(rd, 32'(r[9:2]));
    // standby clears and locks control registers
    apb(1, SADC_IDX_CTRL_ONE, {1'b1, SADC_MODE_SW, 1'b0, ch});
    stby <= 1'b1;
    repeat (6) @(posedge clk);
    chk(32'(smp), 32'h0);
    apb(1, SADC_IDX_CTRL_ONE, 8'h2f);
    apb(0, SADC_IDX_CTRL_ONE, 8'h0); chk(rd, 32'(SADC_CTRL_ONE_RST));
    apb(0, SADC_IDX_CTRL_TWO, 8'h0); chk(rd, 32'(SADC_CTRL_TWO_RST));
    stby <= 1'b0;
    repeat (4) @(posedge clk);
    apb(1, SADC_IDX_CTRL_ONE, 8'h25);
    apb(0, SADC_IDX_CTRL_ONE, 8'h0); chk(rd, 32'h25);
    close_out();
  end
endmodule
